// ### hw/sync_serial_cfg.svh
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH

`define ADDR_TXSC   8'h00
`define ADDR_RXSC   8'h04
`define ADDR_BAUD   8'h08
`define ADDR_DIVLO  8'h0C
`define ADDR_DIVHI  8'h10
`define ADDR_TXDATA 8'h14
`define ADDR_RXDATA 8'h18
`define ADDR_EVENT  8'h1C

`define TXSC_MCS  7
`define TXSC_TX9  6
`define TXSC_TRANSMIT_ENABLE 5
`define TXSC_SYNC 4
`define TXSC_HS   2
`define TXSC_IDLE 1
`define TXSC_TRANSMIT_NINTH_BIT 0

`define RXSC_SERIAL_PORT_ENABLE 7
`define RXSC_RX9  6
`define RXSC_SINGLE_RECEIVE_ENABLE 5
`define RXSC_CONTINUOUS_RECEIVE_ENABLE 4
`define RXSC_OVERRUN_ERROR_FLAG 1
`define RXSC_RECEIVED_NINTH_BIT 0

`define BAUD_POL  4
`define BAUD_WIDE 3

`define EV_RCF 0
`define EV_TXF 1
`define EV_RIE 4
`define EV_TIE 5
`define EV_PIE 6
`define EV_GIE 7

`define RST_BIT  1'b0
`define RST_BYTE 8'h00
`define BITS_NARROW 4'h8
`define BITS_WIDE   4'h9

`endif

// ### hw/sync_serial_pkg.sv
package sync_serial_pkg;
	typedef enum logic {
		PH_LEAD_WAIT  = 1'b0,
		PH_TRAIL_WAIT = 1'b1
	} phase_t;
	typedef logic [8:0] char_t;
endpackage

// ### hw/rx_fifo_if.sv
`timescale 1ns/1ps
interface rx_fifo_if;
	import sync_serial_pkg::*;
	logic  push;
	char_t wdata;
	logic  pop;
	logic  clr;
	logic  full;
	logic  empty;
	char_t top;
	modport owner (output push, wdata, pop, clr, input full, empty, top);
	modport store (input push, wdata, pop, clr, output full, empty, top);
endinterface

// ### hw/rx_char_fifo.sv
`timescale 1ns/1ps
module rx_char_fifo
	import sync_serial_pkg::*;
#(
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// queue
	rx_fifo_if.store fq
);
	localparam int PW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

	if (DEPTH < 2) begin : g_bad_depth
		$error("rx_char_fifo needs DEPTH of at least 2");
	end

	char_t           mem [DEPTH];
	logic [PW-1:0]   wp_r;
	logic [PW-1:0]   rp_r;
	logic [PW:0]     cnt_r;
	logic            do_push;
	logic            do_pop;

	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign fq.full  = (cnt_r == (PW+1)'(DEPTH));
	assign fq.empty = (cnt_r == '0);
	assign fq.top   = mem[rp_r];
	assign do_push  = fq.push & !fq.full;
	assign do_pop   = fq.pop & !fq.empty;

	always_ff @(posedge hclk) begin
		if (do_push && !fq.clr) begin
			mem[wp_r] <= fq.wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (fq.clr) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (do_push) begin
				wp_r <= step(wp_r);
			end
			if (do_pop) begin
				rp_r <= step(rp_r);
			end
			cnt_r <= cnt_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end
endmodule

// ### hw/sync_serial_port.sv
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
// Behaviour
// - receive enables start clocks and shifting
// - receive flag set; request only if enabled
// - overrun cleared by continuous-off or port-off
// - no clock source means external clock slave
// - slave transmits unless a receive enable
// - port enable on with sync set activates, off is inactive
// - first character goes straight to shifter
// - second waits, transmit flag stays clear
// - refill shifter, then transmit flag set
// - transmit flag wakes; vector needs global
// - single receive (master only): one character, self-clears
// - two-deep buffer; third sets overrun, stops
// - data changes leading, one bit per clock
// - polarity sets idle level and change edge
module sync_serial_port
	import sync_serial_pkg::*;
#(
	parameter int RX_DEPTH = 2
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// register bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// data pin
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_oe,
	// clock pin
	input  wire logic        serial_clock_in,
	output logic             serial_clock_out,
	output logic             serial_clock_oe,
	// events towards the core
	output logic             wake_req,
	output logic             irq_req
);
	if (RX_DEPTH != 2) begin : g_bad_depth
		$error("sync_serial_port serves a receive depth of 2 only");
	end

	rx_fifo_if fq ();

	logic        wr_pend_r, rd_pend_r, ap_valid, wr_en;
	logic [7:0]  addr_r, wb, rd_byte;
	logic [31:0] hrdata_r;
	logic        mcs_r, tx9sel_r, transmit_enable_r, sync_r, hs_r, transmit_ninth_bit_r;
	logic        serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, clock_polarity_select_r, wide_r;
	logic        rie_r, tie_r, pie_r, gie_r;
	logic [7:0]  div_lo_r, div_hi_r;
	logic        w_txsc, w_rxsc, w_txd, continuous_receive_enable_fall;
	logic        port_on, rx_mode, tx_mode, rx_active, run_m, tick;
	logic [15:0] brg_cnt_r, divisor;
	phase_t      ph_r;
	logic        m_lead, m_trail, s_lead, s_trail, lead_evt, trail_evt;
	logic        ck_s1, ck_s2, ck_s3, dt_s1, dt_s2, ck_out_r;
	logic [8:0]  txbuf_r, tsr_r, rsr_r, rsr_nxt;
	logic        txbuf_full_r, tx_load, lead_seen_r, dt_out_r, tsr_busy;
	logic [3:0]  tsr_cnt_r, rx_cnt_r, rx_bits;
	logic        rx_done, rx_done_r, overrun_error_flag_r, receive_complete_flag, transmit_buffer_empty_flag;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// bus slave: writes land in the data phase, reads take one wait state
	// so that a read never sees a register one write behind
	assign ap_valid  = hsel & hready & htrans[1];
	assign wr_en     = wr_pend_r;
	assign wb        = hwdata[7:0];
	assign hreadyout = !rd_pend_r;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= `RST_BIT;
			rd_pend_r <= `RST_BIT;
			addr_r    <= `RST_BYTE;
		end else begin
			wr_pend_r <= ap_valid & hwrite;
			rd_pend_r <= ap_valid & !hwrite;
			if (ap_valid) begin
				addr_r <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
		end else if (rd_pend_r) begin
			hrdata_r <= {24'h000000, rd_byte};
		end
	end

	assign w_txsc    = wr_en & hit(addr_r, `ADDR_TXSC);
	assign w_rxsc    = wr_en & hit(addr_r, `ADDR_RXSC);
	assign w_txd     = wr_en & hit(addr_r, `ADDR_TXDATA);
	assign continuous_receive_enable_fall = w_rxsc & continuous_receive_enable_r & !wb[`RXSC_CONTINUOUS_RECEIVE_ENABLE];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mcs_r    <= `RST_BIT;
			tx9sel_r <= `RST_BIT;
			transmit_enable_r   <= `RST_BIT;
			sync_r   <= `RST_BIT;
			hs_r     <= `RST_BIT;
			transmit_ninth_bit_r   <= `RST_BIT;
			serial_port_enable_r   <= `RST_BIT;
			rx9_r    <= `RST_BIT;
			single_receive_enable_r   <= `RST_BIT;
			continuous_receive_enable_r   <= `RST_BIT;
			clock_polarity_select_r   <= `RST_BIT;
			wide_r   <= `RST_BIT;
			div_lo_r <= `RST_BYTE;
			div_hi_r <= `RST_BYTE;
			rie_r    <= `RST_BIT;
			tie_r    <= `RST_BIT;
			pie_r    <= `RST_BIT;
			gie_r    <= `RST_BIT;
		end else begin
			if (w_txsc) begin
				mcs_r    <= wb[`TXSC_MCS];
				tx9sel_r <= wb[`TXSC_TX9];
				transmit_enable_r   <= wb[`TXSC_TRANSMIT_ENABLE];
				sync_r   <= wb[`TXSC_SYNC];
				hs_r     <= wb[`TXSC_HS];
				transmit_ninth_bit_r   <= wb[`TXSC_TRANSMIT_NINTH_BIT];
			end
			if (w_rxsc) begin
				serial_port_enable_r <= wb[`RXSC_SERIAL_PORT_ENABLE];
				rx9_r  <= wb[`RXSC_RX9];
				single_receive_enable_r <= wb[`RXSC_SINGLE_RECEIVE_ENABLE];
				continuous_receive_enable_r <= wb[`RXSC_CONTINUOUS_RECEIVE_ENABLE];
			end else if (rx_done && mcs_r) begin
				single_receive_enable_r <= 1'b0;
			end
			if (wr_en && hit(addr_r, `ADDR_BAUD)) begin
				clock_polarity_select_r <= wb[`BAUD_POL];
				wide_r <= wb[`BAUD_WIDE];
			end
			if (wr_en && hit(addr_r, `ADDR_DIVLO)) begin
				div_lo_r <= wb;
			end
			if (wr_en && hit(addr_r, `ADDR_DIVHI)) begin
				div_hi_r <= wb;
			end
			if (wr_en && hit(addr_r, `ADDR_EVENT)) begin
				rie_r <= wb[`EV_RIE];
				tie_r <= wb[`EV_TIE];
				pie_r <= wb[`EV_PIE];
				gie_r <= wb[`EV_GIE];
			end
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (hit(addr_r, `ADDR_TXSC)) begin
			rd_byte[`TXSC_MCS]  = mcs_r;
			rd_byte[`TXSC_TX9]  = tx9sel_r;
			rd_byte[`TXSC_TRANSMIT_ENABLE] = transmit_enable_r;
			rd_byte[`TXSC_SYNC] = sync_r;
			rd_byte[`TXSC_HS]   = hs_r;
			rd_byte[`TXSC_IDLE] = !tsr_busy;
			rd_byte[`TXSC_TRANSMIT_NINTH_BIT] = transmit_ninth_bit_r;
		end else if (hit(addr_r, `ADDR_RXSC)) begin
			rd_byte[`RXSC_SERIAL_PORT_ENABLE] = serial_port_enable_r;
			rd_byte[`RXSC_RX9]  = rx9_r;
			rd_byte[`RXSC_SINGLE_RECEIVE_ENABLE] = single_receive_enable_r;
			rd_byte[`RXSC_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable_r;
			rd_byte[`RXSC_OVERRUN_ERROR_FLAG] = overrun_error_flag_r;
			rd_byte[`RXSC_RECEIVED_NINTH_BIT] = fq.top[8] & !fq.empty;
		end else if (hit(addr_r, `ADDR_BAUD)) begin
			rd_byte[`BAUD_POL]  = clock_polarity_select_r;
			rd_byte[`BAUD_WIDE] = wide_r;
		end else if (hit(addr_r, `ADDR_DIVLO)) begin
			rd_byte = div_lo_r;
		end else if (hit(addr_r, `ADDR_DIVHI)) begin
			rd_byte = div_hi_r;
		end else if (hit(addr_r, `ADDR_RXDATA)) begin
			// queue memory has no reset, so an empty queue reads zero
			rd_byte = fq.empty ? 8'h00 : fq.top[7:0];
		end else if (hit(addr_r, `ADDR_EVENT)) begin
			rd_byte[`EV_RCF] = receive_complete_flag;
			rd_byte[`EV_TXF] = transmit_buffer_empty_flag;
			rd_byte[`EV_RIE] = rie_r;
			rd_byte[`EV_TIE] = tie_r;
			rd_byte[`EV_PIE] = pie_r;
			rd_byte[`EV_GIE] = gie_r;
		end
	end

	// modes; asynchronous framing is not built, so sync clear keeps it idle
	assign port_on   = serial_port_enable_r & sync_r;
	assign rx_mode   = single_receive_enable_r | continuous_receive_enable_r;
	assign tx_mode   = transmit_enable_r & !rx_mode;
	assign rx_active = port_on & rx_mode & !overrun_error_flag_r;

	// bit clock: one half period per divisor match
	assign divisor = wide_r ? {div_hi_r, div_lo_r} : {8'h00, div_lo_r};
	// rx_done_r pauses a cycle so a zero divisor cannot add a stray edge
	assign run_m = port_on & mcs_r & !rx_done_r & (rx_active | (tx_mode & tsr_busy));
	assign tick  = run_m & (brg_cnt_r == divisor);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brg_cnt_r <= 16'h0000;
		end else if (!run_m || tick) begin
			brg_cnt_r <= 16'h0000;
		end else begin
			brg_cnt_r <= brg_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_r <= PH_LEAD_WAIT;
		end else if (!run_m) begin
			ph_r <= PH_LEAD_WAIT;
		end else if (tick) begin
			case (ph_r)
				PH_LEAD_WAIT:  ph_r <= PH_TRAIL_WAIT;
				PH_TRAIL_WAIT: ph_r <= PH_LEAD_WAIT;
				default:       ph_r <= PH_LEAD_WAIT;
			endcase
		end
	end

	assign m_lead  = tick & (ph_r == PH_LEAD_WAIT);
	assign m_trail = tick & (ph_r == PH_TRAIL_WAIT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_s3 <= 1'b0;
			dt_s1 <= 1'b0;
			dt_s2 <= 1'b0;
		end else begin
			ck_s1 <= serial_clock_in;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			dt_s1 <= serial_data_in;
			dt_s2 <= dt_s1;
		end
	end

	// idle-high clock leads with a fall, idle-low with a rise
	assign s_lead    = clock_polarity_select_r ? (!ck_s2 & ck_s3) : (ck_s2 & !ck_s3);
	assign s_trail   = clock_polarity_select_r ? (ck_s2 & !ck_s3) : (!ck_s2 & ck_s3);
	assign lead_evt  = port_on & (mcs_r ? m_lead : s_lead);
	assign trail_evt = port_on & (mcs_r ? m_trail : s_trail);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_out_r <= 1'b0;
		end else begin
			ck_out_r <= clock_polarity_select_r ^ (ph_r == PH_TRAIL_WAIT);
		end
	end

	assign serial_clock_out = ck_out_r;
	assign serial_clock_oe  = port_on & mcs_r;
	assign serial_data_out  = dt_out_r;
	assign serial_data_oe   = port_on & tx_mode;

	// transmit: one buffered character behind the shifter
	assign tsr_busy = (tsr_cnt_r != 4'h0);
	assign tx_load  = txbuf_full_r & !tsr_busy & tx_mode & port_on;
	assign transmit_buffer_empty_flag     = !txbuf_full_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txbuf_r      <= 9'h000;
			txbuf_full_r <= 1'b0;
		end else if (!serial_port_enable_r) begin
			txbuf_full_r <= 1'b0;
		end else if (w_txd) begin
			txbuf_r      <= {transmit_ninth_bit_r, wb};
			txbuf_full_r <= 1'b1;
		end else if (tx_load) begin
			txbuf_full_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tsr_r       <= 9'h000;
			tsr_cnt_r   <= 4'h0;
			lead_seen_r <= 1'b0;
			dt_out_r    <= 1'b0;
		end else if (!serial_port_enable_r) begin
			tsr_cnt_r   <= 4'h0;
			lead_seen_r <= 1'b0;
			dt_out_r    <= 1'b0;
		end else if (tx_load) begin
			tsr_r       <= txbuf_r;
			tsr_cnt_r   <= tx9sel_r ? `BITS_WIDE : `BITS_NARROW;
			lead_seen_r <= 1'b0;
		end else if (lead_evt && tsr_busy && tx_mode) begin
			dt_out_r    <= tsr_r[0];
			tsr_r       <= {1'b0, tsr_r[8:1]};
			lead_seen_r <= 1'b1;
		end else if (trail_evt && tsr_busy && lead_seen_r) begin
			tsr_cnt_r   <= tsr_cnt_r - 4'h1;
			lead_seen_r <= 1'b0;
		end
	end

	// receive: sample on the trailing edge, lsb first
	assign rx_bits = rx9_r ? `BITS_WIDE : `BITS_NARROW;
	assign rsr_nxt = {dt_s2, rsr_r[8:1]};
	assign rx_done = rx_active & trail_evt & (rx_cnt_r == rx_bits - 4'h1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rsr_r     <= 9'h000;
			rx_cnt_r  <= 4'h0;
			rx_done_r <= 1'b0;
		end else begin
			rx_done_r <= rx_done;
			if (!rx_active) begin
				rx_cnt_r <= 4'h0; // partial character discarded
			end else if (trail_evt) begin
				rsr_r    <= rsr_nxt;
				rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
			end
		end
	end

	assign fq.push  = rx_done & !fq.full;
	assign fq.wdata = rx9_r ? rsr_nxt : {1'b0, rsr_nxt[8:1]};
	assign fq.pop   = rd_pend_r & hit(addr_r, `ADDR_RXDATA) & !fq.empty;
	assign fq.clr   = !serial_port_enable_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_error_flag_r <= 1'b0;
		end else if (rx_done && fq.full) begin
			overrun_error_flag_r <= 1'b1;
		end else if (!serial_port_enable_r || continuous_receive_enable_fall || (fq.pop && !continuous_receive_enable_r)) begin
			overrun_error_flag_r <= 1'b0;
		end
	end

	rx_char_fifo #(
		.DEPTH (RX_DEPTH)
	) u_fifo (
		.hclk    (hclk),
		.hresetn (hresetn),
		.fq      (fq.store)
	);

	assign receive_complete_flag     = !fq.empty;
	assign wake_req = pie_r & ((rie_r & receive_complete_flag) | (tie_r & transmit_buffer_empty_flag));
	assign irq_req  = wake_req & gie_r;

	default clocking dc @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence last_out;
		port_on && tx_mode && tsr_busy && tsr_cnt_r == 4'h1 && lead_seen_r
		&& trail_evt && txbuf_full_r && !w_txd;
	endsequence

	chk_receive_complete_flag_set: assert property (fq.push && fq.empty && serial_port_enable_r |=> receive_complete_flag)
		else $error("receive flag not raised");
	chk_irq_gate: assert property (
		(receive_complete_flag && !rie_r && !(tie_r && transmit_buffer_empty_flag)) |-> !irq_req && !wake_req)
		else $error("request without enable");
	chk_tx_wake: assert property (
		(pie_r && tie_r && transmit_buffer_empty_flag) |-> wake_req && (irq_req == gie_r))
		else $error("transmit wake wrong");
	chk_single_stop: assert property (
		(rx_done && mcs_r && !continuous_receive_enable_r && !transmit_enable_r && !w_rxsc)
		|=> !single_receive_enable_r && !lead_evt ##1 !lead_evt)
		else $error("single receive did not stop");
	chk_overrun_hold: assert property (
		(rx_done && fq.full && !fq.pop) |=> overrun_error_flag_r && fq.full && !fq.push)
		else $error("overrun handling wrong");
	chk_overrun_error_flag_clear: assert property (
		(overrun_error_flag_r && continuous_receive_enable_fall) |=> !overrun_error_flag_r)
		else $error("overrun not cleared");
	chk_serial_port_enable_reset: assert property (
		!serial_port_enable_r |=> !overrun_error_flag_r && fq.empty && !tsr_busy && transmit_buffer_empty_flag)
		else $error("port not reset");
	chk_slave_clk: assert property (
		(port_on && !mcs_r) |-> !serial_clock_oe && !m_lead && !m_trail)
		else $error("slave drives a clock");
	chk_slave_rx_mode: assert property (
		(port_on && rx_mode) |-> !serial_data_oe)
		else $error("data driven while receiving");
	chk_hold_flag: assert property (
		last_out |-> !transmit_buffer_empty_flag ##1 (!tsr_busy && !transmit_buffer_empty_flag))
		else $error("transmit flag set early");
	chk_refill_order: assert property (
		last_out ##1 (!w_txd && port_on) |=> tsr_busy && transmit_buffer_empty_flag)
		else $error("buffer not moved to shifter");
	chk_data_on_lead: assert property (
		$changed(dt_out_r) |-> $past(lead_evt) || !$past(serial_port_enable_r))
		else $error("data changed off leading edge");
	chk_clock_idle: assert property (
		(mcs_r && !run_m && $stable(clock_polarity_select_r))[*3] |-> serial_clock_out == clock_polarity_select_r)
		else $error("idle clock level wrong");
endmodule

// ### tb/sync_peer.sv
`timescale 1ns/1ps
module sync_peer (
	// link pins
	input  wire logic pin_clk,
	input  wire logic pin_data,
	output logic      clk_drv,
	output logic      data_drv,
	// bench setup
	input  wire logic pol,
	input  wire logic nine,
	input  wire logic rx_on
);
	logic [8:0] q[$];
	int         bitn;
	initial begin
		clk_drv = 1'b0;
		data_drv = 1'b1;
		bitn = 0;
	end
	// released line keeps toggling so a stale level never passes
	always @(pin_clk) begin
		if (!rx_on) begin
			bitn = 0;
			data_drv <= ~data_drv;
		end else if (pin_clk !== pol && q.size() > 0) begin
			data_drv <= q[0][bitn];
			bitn++;
			if (bitn == (nine ? 9 : 8)) begin
				bitn = 0;
				void'(q.pop_front());
			end
		end
	end
	// long lead half: the slave answers some system clocks after the edge
	task automatic frame(input int n, output logic [8:0] got);
		got = 9'h000;
		#7;
		for (int i = 0; i < n; i++) begin
			clk_drv = ~pol;
			#250;
			clk_drv = pol;
			got[i] = pin_data;
			#150;
		end
	endtask
endmodule

// ### tb/sync_serial_port_tb.sv
`timescale 1ns/1ps
`include "sync_serial_cfg.svh"
module sync_serial_port_tb;
	import sync_serial_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        serial_data_out;
	logic        serial_data_oe;
	logic        serial_clock_out;
	logic        serial_clock_oe;
	logic        wake_req;
	logic        irq_req;
	logic        clk_drv;
	logic        data_drv;
	logic        pol;
	logic        nine;
	logic        rx_on;
	wire         clk_pin  = serial_clock_oe ? serial_clock_out : clk_drv;
	wire         data_pin = serial_data_oe ? serial_data_out : data_drv;
	int          errors;
	int          compares;
	int          edges;
	logic [15:0] seed;
	char_t       exp_q[$];
	char_t       got;
	logic [31:0] rd;
	logic [7:0]  addrs[9] = '{`ADDR_TXSC, `ADDR_RXSC, `ADDR_BAUD, `ADDR_DIVLO, `ADDR_DIVHI,
		`ADDR_TXDATA, `ADDR_RXDATA, `ADDR_EVENT, 8'h20};
	// idle shifter and empty transmit buffer read as set after reset
	logic [7:0]  rst_exp[9] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};

	sync_serial_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_data_in(data_pin),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
		.serial_clock_in(clk_pin), .serial_clock_out(serial_clock_out),
		.serial_clock_oe(serial_clock_oe), .wake_req(wake_req), .irq_req(irq_req));
	sync_peer peer_u (.pin_clk(clk_pin), .pin_data(data_pin), .clk_drv(clk_drv),
		.data_drv(data_drv), .pol(pol), .nine(nine), .rx_on(rx_on));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	always @(clk_pin) if (rx_on && clk_pin !== pol) edges++;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
		compares++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t ns: %s got %h expected %h", $time, what, g, e);
		end
	endtask
	// entered just after a rising edge; hsel stays high, htrans marks transfers
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
		if (n >= 50) begin
			errors++;
			$display("wrong value at %0t ns: bus hung", $time);
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
		bus(1'b0, a, 32'h0);
		chk(rd, e, what);
	endtask
	task automatic poll(input logic [7:0] a, input int b);
		int n;
		n = 0;
		do begin bus(1'b0, a, 32'h0); n++; end while (rd[b] !== 1'b1 && n < 500);
		if (n >= 500) begin
			errors++;
			$display("wrong value at %0t ns: flag never rose", $time);
			tally_and_finish();
		end
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		pol = 1'b0;
		nine = 1'b0;
		rx_on = 1'b0;
		errors = 0;
		compares = 0;
		edges = 0;
		seed = 16'h1C88;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (addrs[i]) rdc(addrs[i], {24'h0, rst_exp[i]}, "reset value");
		seed = lfsr(seed);
		wr(`ADDR_DIVLO, seed[7:0]);
		wr(`ADDR_DIVHI, seed[15:8]);
		rdc(`ADDR_DIVLO, {24'h0, seed[7:0]}, "divisor low");
		rdc(`ADDR_DIVHI, {24'h0, seed[15:8]}, "divisor high");
		wr(8'h24, 8'hFF);
		rdc(8'h24, 32'h0, "unmapped");
		// master single receive at both clock polarities
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			wr(`ADDR_BAUD, {3'h0, pol, 4'h0});
			wr(`ADDR_DIVLO, 8'h03);
			wr(`ADDR_DIVHI, 8'h00);
			wr(`ADDR_TXSC, 8'h90);
			wr(`ADDR_RXSC, 8'h80);
			@(posedge hclk);
			chk({31'h0, serial_clock_oe}, 32'h1, "master drives clock");
			chk({31'h0, serial_clock_out}, {31'h0, pol}, "idle level");
			seed = lfsr(seed);
			peer_u.q.push_back({1'b0, seed[7:0]});
			exp_q.push_back({1'b0, seed[7:0]});
			edges = 0;
			rx_on = 1'b1;
			wr(`ADDR_RXSC, 8'hA0);
			@(posedge hclk);
			chk({31'h0, serial_data_oe}, 32'h0, "data pin released");
			poll(`ADDR_EVENT, `EV_RCF);
			chk(edges, 8, "clock count");
			rdc(`ADDR_RXSC, 32'h80, "single receive cleared");
			got = exp_q.pop_front();
			rdc(`ADDR_RXDATA, {24'h0, got[7:0]}, "received byte");
			rdc(`ADDR_EVENT, 32'h02, "flag after read");
			chk({31'h0, serial_clock_out}, {31'h0, pol}, "idle after char");
			rx_on = 1'b0;
		end
		// continuous nine-bit receive into overrun
		pol = 1'b0;
		wr(`ADDR_BAUD, 8'h00);
		wr(`ADDR_EVENT, 8'h50);
		nine = 1'b1;
		repeat (3) begin
			seed = lfsr(seed);
			peer_u.q.push_back(seed[8:0]);
			exp_q.push_back(seed[8:0]);
		end
		void'(exp_q.pop_back());
		rx_on = 1'b1;
		wr(`ADDR_RXSC, 8'hD0);
		poll(`ADDR_RXSC, `RXSC_OVERRUN_ERROR_FLAG);
		chk({31'h0, wake_req}, 32'h1, "receive wake");
		chk({31'h0, irq_req}, 32'h0, "no vector");
		wr(`ADDR_EVENT, 8'hD0);
		@(posedge hclk);
		chk({31'h0, irq_req}, 32'h1, "vector");
		wr(`ADDR_RXSC, 8'hC0);
		rx_on = 1'b0;
		peer_u.q.delete();
		got = exp_q.pop_front();
		rdc(`ADDR_RXSC, {24'h0, 7'h60, got[8]}, "overrun cleared");
		rdc(`ADDR_RXDATA, {24'h0, got[7:0]}, "first kept");
		got = exp_q.pop_front();
		rdc(`ADDR_RXSC, {24'h0, 7'h60, got[8]}, "second ninth");
		rdc(`ADDR_RXDATA, {24'h0, got[7:0]}, "second kept");
		rdc(`ADDR_EVENT, 32'hD2, "buffer empty");
		nine = 1'b0;
		// slave transmit of two nine-bit characters
		wr(`ADDR_EVENT, 8'h60);
		wr(`ADDR_TXSC, 8'h71);
		wr(`ADDR_RXSC, 8'h80);
		@(posedge hclk);
		chk({31'h0, serial_clock_oe}, 32'h0, "slave clock");
		chk({31'h0, serial_data_oe}, 32'h1, "slave drives data");
		seed = lfsr(seed);
		wr(`ADDR_TXDATA, seed[7:0]);
		wr(`ADDR_TXDATA, seed[15:8]);
		rdc(`ADDR_EVENT, 32'h60, "buffer held");
		chk({31'h0, wake_req}, 32'h0, "no wake yet");
		peer_u.frame(9, got);
		@(posedge hclk);
		chk({23'h0, got}, {23'h0, 1'b1, seed[7:0]}, "first out");
		poll(`ADDR_EVENT, `EV_TXF);
		chk({31'h0, wake_req}, 32'h1, "transmit wake");
		chk({31'h0, irq_req}, 32'h0, "no vector");
		peer_u.frame(9, got);
		@(posedge hclk);
		chk({23'h0, got}, {23'h0, 1'b1, seed[15:8]}, "second out");
		chk({31'h0, serial_clock_oe}, 32'h0, "still no clock");
		wr(`ADDR_RXSC, 8'h00);
		@(posedge hclk);
		chk({31'h0, serial_data_oe}, 32'h0, "port off");
		tally_and_finish();
	end
endmodule
